/* hdl/evte_defines.svh */
// constants for the egress vlan tag editor: offsets, fields, resets
`ifndef EVTE_DEFINES_SVH
`define EVTE_DEFINES_SVH

// ==========================================================================
// sizes
`define EVTE_NP          4
`define EVTE_MAX_TAGS    3'h3

// ==========================================================================
// register byte addresses (low eight address bits are decoded)
`define EVTE_A_CTRL      8'h00
`define EVTE_A_COLOR_MAP 8'h04
`define EVTE_A_TPID0     8'h08
`define EVTE_A_STATUS    8'h14
`define EVTE_A_PORT_HI   2'h1
`define EVTE_A_DEI_HI    4'h8
`define EVTE_R_VLAN      2'h0
`define EVTE_R_TAGCTL    2'h1
`define EVTE_R_PCP_DE0   2'h2
`define EVTE_R_PCP_DE1   2'h3

// ==========================================================================
// field positions
`define EVTE_F_MODE      1:0
`define EVTE_F_OBEY      2
`define EVTE_F_TPIDSEL   6:4
`define EVTE_F_VIDSEL    8
`define EVTE_F_PCPSEL    10:9
`define EVTE_F_DEISEL    13:12

// ==========================================================================
// reset values and fixed protocol ids
`define EVTE_RST_TPID    16'h8100
`define EVTE_RST_PVLAN   16'h0001
`define EVTE_RST_TAGCTL  14'h0003
`define EVTE_RST_CMAP    4'hc
`define EVTE_TPID_C      16'h8100
`define EVTE_TPID_S      16'h88a8

`endif

/* hdl/evte_pkg.sv */
// types of the egress vlan tag editor
package evte_pkg;
`include "evte_defines.svh"

    typedef enum logic [2:0]
    {
        EVTE_SRC_NONE  = 3'h0,
        EVTE_SRC_PORT  = 3'h1,
        EVTE_SRC_CLS_A = 3'h2,
        EVTE_SRC_CLS_B = 3'h3,
        EVTE_SRC_CLS_C = 3'h4,
        EVTE_SRC_ROUTE = 3'h5
    } evte_src_t;

    typedef enum logic [1:0]
    {
        EVTE_TAG_ALL      = 2'h0,
        EVTE_TAG_EXC_PVID = 2'h1,
        EVTE_TAG_EXC_VID0 = 2'h2,
        EVTE_TAG_NONE     = 2'h3
    } evte_mode_t;

    typedef struct packed {
        logic                                cls_en;
        logic [3:0]                          color_map;
        logic [2:0][15:0]                    tpid;
        logic [`EVTE_NP-1:0][15:0]           pvlan;
        logic [`EVTE_NP-1:0][13:0]           tagctl;
        logic [`EVTE_NP-1:0][1:0][23:0]      pcp_map;
        logic [`EVTE_NP-1:0][15:0]           dei_map;
        logic [15:0]                         frm_cnt;
        logic                                a_sel;
        logic                                a_wr;
        logic [7:0]                          a_addr;
        logic [31:0]                         hrdata;
        logic                                hready;
        logic                                fi_ready;
        logic                                fo_valid;
        logic [1:0]                          fo_pop;
        logic [1:0]                          fo_push;
        logic [2:0][2:0]                     fo_src;
        logic [31:0]                         fo_tag;
        logic                                fo_color;
    } evte_st_t;

endpackage : evte_pkg

/* hdl/evte_editor.sv */
// egress vlan tag editor: pop/push decision, port tag build, ahb-lite regs
`timescale 1ns/100ps
module evte_editor
    import evte_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        fi_valid,
    output logic             fi_ready,
    input  wire logic [1:0]  fi_port,
    input  wire logic [1:0]  fi_pop_req,
    input  wire logic [1:0]  fi_push_req,
    input  wire logic        fi_orig_tagged,
    input  wire logic [2:0]  fi_qos,
    input  wire logic [1:0]  fi_dp,
    input  wire logic [11:0] fi_vid,
    input  wire logic [2:0]  fi_pcp,
    input  wire logic        fi_dei,
    input  wire logic        fi_routed,
    input  wire logic [11:0] fi_route_vid,
    input  wire logic [15:0] fi_etype0,
    input  wire logic [15:0] fi_etype1,
    input  wire logic [15:0] fi_etype2,
    input  wire logic        fi_cls_hit,
    input  wire logic [1:0]  fi_cls_pop,
    input  wire logic [1:0]  fi_cls_outer,
    input  wire logic        fi_cls_inner,
    input  wire logic [1:0]  fi_cls_cust,
    output logic             fo_valid,
    input  wire logic        fo_ready,
    output logic [1:0]       fo_pop_cnt,
    output logic [1:0]       fo_push_cnt,
    output logic [2:0]       fo_src0,
    output logic [2:0]       fo_src1,
    output logic [2:0]       fo_src2,
    output logic [31:0]      fo_port_tag,
    output logic             fo_color
);

    // ======================================================================
    // state
    evte_st_t q;
    evte_st_t d;

    logic [2:0][15:0] etype;
    logic [2:0]       qmatch;
    logic [2:0]       num_qtags;
    logic             hit;
    logic [2:0]       cls_pop;
    logic [2:0]       push_req;
    logic [2:0]       d_pop;
    logic [2:0]       pop_sum;
    logic [2:0]       pop_sat;
    logic [2:0]       tot_pop;
    logic             tag_a;
    logic             tag_b;
    logic             tag_c;
    logic             cls_mode;
    logic [2:0]       rew_push;
    logic [2:0]       d_push;
    logic [2:0]       push_sum;
    logic [2:0]       cls_push;
    logic [15:0]      pvlan;
    logic [13:0]      tctl;
    logic [11:0]      pvid;
    logic             mode_ok;
    logic             port_push;
    logic [2:0]       port_cnt;
    logic             color;
    logic [15:0]      tag_tpid;
    logic [11:0]      tag_vid;
    logic [2:0]       tag_pcp;
    logic             tag_dei;
    logic [2:0]       tpsel;
    logic [7:0]       raddr;
    logic             rd_req;
    logic [31:0]      rval;
    logic [7:0]       wa;

    // ======================================================================
    // q-tag count over the leading ethertypes, outermost first
    assign etype = {fi_etype2, fi_etype1, fi_etype0};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_qmatch
            assign qmatch[gi] = (etype[gi] == `EVTE_TPID_C) ||
                                (etype[gi] == `EVTE_TPID_S) ||
                                (etype[gi] == q.tpid[0]) ||
                                (etype[gi] == q.tpid[1]) ||
                                (etype[gi] == q.tpid[2]);
        end
    endgenerate

    // an inner match behind a non-tag ethertype is payload, not a tag
    assign num_qtags = !qmatch[0] ? 3'h0 :
                       !qmatch[1] ? 3'h1 :
                       !qmatch[2] ? 3'h2 : 3'h3;

    // ======================================================================
    // stage 1: classifier lookup result
    assign hit      = q.cls_en && fi_cls_hit;
    assign cls_pop  = hit ? {1'b0, fi_cls_pop} : 3'h0;
    // push request counts only while the classifier runs
    assign push_req = q.cls_en ? {1'b0, fi_push_req} : 3'h0;

    // ======================================================================
    // stage 2: pop decision
    assign d_pop   = (cls_pop > push_req) ? 3'(cls_pop - push_req) : 3'h0;
    assign pop_sum = 3'({1'b0, fi_pop_req} + d_pop);
    assign pop_sat = (pop_sum > `EVTE_MAX_TAGS) ? `EVTE_MAX_TAGS : pop_sum;
    assign tot_pop = (pop_sat > num_qtags) ? num_qtags : pop_sat;

    // ======================================================================
    // stage 3: push decision
    assign tag_a    = hit && (fi_cls_outer == 2'h1);
    assign tag_b    = hit && fi_cls_inner;
    assign tag_c    = hit && (fi_cls_cust == 2'h3);
    // outer action 1 or 3 hands all slots to classifier tags
    assign cls_mode = hit && fi_cls_outer[0];
    assign rew_push = 3'({2'h0, tag_a} + {2'h0, tag_b} + {2'h0, tag_c});
    assign d_push   = (push_req > cls_pop) ? 3'(push_req - cls_pop) : 3'h0;
    assign push_sum = 3'(rew_push + d_push);
    assign cls_push = (push_sum > `EVTE_MAX_TAGS) ? `EVTE_MAX_TAGS : push_sum;

    assign pvlan   = q.pvlan[fi_port];
    assign tctl    = q.tagctl[fi_port];
    assign pvid    = pvlan[11:0];
    assign mode_ok = (tctl[`EVTE_F_MODE] == EVTE_TAG_ALL) ||
                     ((tctl[`EVTE_F_MODE] == EVTE_TAG_EXC_PVID) &&
                      (fi_vid != 12'h000) && (fi_vid != pvid)) ||
                     ((tctl[`EVTE_F_MODE] == EVTE_TAG_EXC_VID0) &&
                      (fi_vid != 12'h000));

    // outer action 2 forces the port tag past the port mode
    assign port_push = (hit && (fi_cls_outer == 2'h2)) ||
                       (mode_ok && (!tctl[`EVTE_F_OBEY] || fi_orig_tagged));
    assign port_cnt  = 3'({2'h0, port_push} + {2'h0, tag_b});

    // ======================================================================
    // stage 4: port tag construction
    assign color = q.color_map[fi_dp];
    assign tpsel = tctl[`EVTE_F_TPIDSEL];
    assign tag_tpid = (tpsel == 3'h0) ? `EVTE_TPID_C :
                      (tpsel == 3'h1) ? `EVTE_TPID_S :
                      (tpsel == 3'h2) ? q.tpid[0] :
                      (tpsel == 3'h3) ? q.tpid[1] :
                      (tpsel == 3'h4) ? q.tpid[2] : `EVTE_TPID_C;
    assign tag_vid = tctl[`EVTE_F_VIDSEL] ? pvid :
                     fi_routed ? fi_route_vid : fi_vid;
    assign tag_pcp = (tctl[`EVTE_F_PCPSEL] == 2'h1) ? pvlan[14:12] :
                     (tctl[`EVTE_F_PCPSEL] == 2'h2) ?
                         q.pcp_map[fi_port][color][fi_qos*3 +: 3] :
                         fi_pcp;
    assign tag_dei = (tctl[`EVTE_F_DEISEL] == 2'h1) ? pvlan[15] :
                     (tctl[`EVTE_F_DEISEL] == 2'h2) ?
                         q.dei_map[fi_port][{color, fi_qos}] :
                     (tctl[`EVTE_F_DEISEL] == 2'h3) ? color :
                         fi_dei;

    // ======================================================================
    // register read mux
    assign raddr  = haddr[7:0];
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    assign wa     = q.a_addr;

    always_comb
    begin
        rval = 32'h0000_0000;
        if (raddr == `EVTE_A_CTRL)
        begin
            rval = {31'h0, d.cls_en};
        end
        else if (raddr == `EVTE_A_COLOR_MAP)
        begin
            rval = {28'h0, d.color_map};
        end
        else if ((raddr >= `EVTE_A_TPID0) && (raddr < `EVTE_A_STATUS) &&
                 (raddr[1:0] == 2'h0))
        begin
            rval = {16'h0, d.tpid[2'(raddr[3:2] - 2'h2)]};
        end
        else if (raddr == `EVTE_A_STATUS)
        begin
            rval = {15'h0, d.fo_valid, d.frm_cnt};
        end
        else if ((raddr[7:6] == `EVTE_A_PORT_HI) && (raddr[1:0] == 2'h0))
        begin
            case (raddr[3:2])
                `EVTE_R_VLAN:    rval = {16'h0, d.pvlan[raddr[5:4]]};
                `EVTE_R_TAGCTL:  rval = {18'h0, d.tagctl[raddr[5:4]]};
                `EVTE_R_PCP_DE0: rval = {8'h0, d.pcp_map[raddr[5:4]][0]};
                `EVTE_R_PCP_DE1: rval = {8'h0, d.pcp_map[raddr[5:4]][1]};
                default:         rval = 32'h0000_0000;
            endcase
        end
        else if ((raddr[7:4] == `EVTE_A_DEI_HI) && (raddr[1:0] == 2'h0))
        begin
            rval = {16'h0, d.dei_map[raddr[3:2]]};
        end
    end

    // ======================================================================
    // next state
    always_comb
    begin
        d = q;
        // write data phase lands before the read mux samples d
        if (q.a_sel && q.a_wr)
        begin
            if (wa == `EVTE_A_CTRL)
            begin
                d.cls_en = hwdata[0];
            end
            else if (wa == `EVTE_A_COLOR_MAP)
            begin
                d.color_map = hwdata[3:0];
            end
            else if ((wa >= `EVTE_A_TPID0) && (wa < `EVTE_A_STATUS) &&
                     (wa[1:0] == 2'h0))
            begin
                d.tpid[2'(wa[3:2] - 2'h2)] = hwdata[15:0];
            end
            else if ((wa[7:6] == `EVTE_A_PORT_HI) && (wa[1:0] == 2'h0))
            begin
                case (wa[3:2])
                    `EVTE_R_VLAN:    d.pvlan[wa[5:4]] = hwdata[15:0];
                    `EVTE_R_TAGCTL:  d.tagctl[wa[5:4]] = hwdata[13:0];
                    `EVTE_R_PCP_DE0: d.pcp_map[wa[5:4]][0] = hwdata[23:0];
                    `EVTE_R_PCP_DE1: d.pcp_map[wa[5:4]][1] = hwdata[23:0];
                    default:         d.pvlan[wa[5:4]] = q.pvlan[wa[5:4]];
                endcase
            end
            else if ((wa[7:4] == `EVTE_A_DEI_HI) && (wa[1:0] == 2'h0))
            begin
                d.dei_map[wa[3:2]] = hwdata[15:0];
            end
        end
        d.a_sel  = hsel && hready && htrans[1];
        d.a_wr   = hwrite;
        d.a_addr = raddr;
        d.hready = 1'b1;

        // frame path: one frame held at the output until taken
        if (q.fo_valid && fo_ready)
        begin
            d.fo_valid = 1'b0;
            d.fi_ready = 1'b1;
        end
        // all five stages settle in the accept cycle
        if (fi_valid && q.fi_ready)
        begin
            d.fi_ready = 1'b0;
            d.fo_valid = 1'b1;
            d.frm_cnt  = 16'(q.frm_cnt + 16'h1);
            // pop count applies from the outermost tag inward
            d.fo_pop   = tot_pop[1:0];
            d.fo_color = color;
            d.fo_tag   = {tag_tpid, tag_pcp, tag_dei, tag_vid};
            if (cls_mode)
            begin
                // stage 5 order a, b, c; extras only ever classifier tags
                d.fo_push   = cls_push[1:0];
                d.fo_src[0] = (cls_push > 3'h0) ? EVTE_SRC_CLS_A : EVTE_SRC_NONE;
                d.fo_src[1] = (cls_push > 3'h1) ? EVTE_SRC_CLS_B : EVTE_SRC_NONE;
                d.fo_src[2] = (cls_push > 3'h2) ? EVTE_SRC_CLS_C : EVTE_SRC_NONE;
            end
            else
            begin
                // port-led outer tag; routed frames take the routing tag
                d.fo_push   = port_cnt[1:0];
                d.fo_src[0] = port_push ? (fi_routed ? EVTE_SRC_ROUTE : EVTE_SRC_PORT) :
                              tag_b ? EVTE_SRC_CLS_B : EVTE_SRC_NONE;
                d.fo_src[1] = (port_push && tag_b) ? EVTE_SRC_CLS_B : EVTE_SRC_NONE;
                d.fo_src[2] = EVTE_SRC_NONE;
            end
        end
        d.hrdata = rd_req ? rval : 32'h0000_0000;
    end

    // ======================================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q           <= '0;
            q.color_map <= `EVTE_RST_CMAP;
            q.tpid      <= {3{`EVTE_RST_TPID}};
            q.pvlan     <= {`EVTE_NP{`EVTE_RST_PVLAN}};
            q.tagctl    <= {`EVTE_NP{`EVTE_RST_TAGCTL}};
            q.hready    <= 1'b1;
            q.fi_ready  <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ======================================================================
    // outputs
    assign hreadyout   = q.hready;
    assign hresp       = q.a_sel & 1'b0;
    assign hrdata      = q.hrdata;
    assign fi_ready    = q.fi_ready;
    assign fo_valid    = q.fo_valid;
    assign fo_pop_cnt  = q.fo_pop;
    assign fo_push_cnt = q.fo_push;
    assign fo_src0     = q.fo_src[0];
    assign fo_src1     = q.fo_src[1];
    assign fo_src2     = q.fo_src[2];
    assign fo_port_tag = q.fo_tag;
    assign fo_color    = q.fo_color;

endmodule : evte_editor

/* testbench/evte_checker.sv */
// concurrent checks on the tag editor's frame ports; bus writes are only tracked
`timescale 1ns/100ps
module evte_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        fi_valid,
    input wire logic        fi_ready,
    input wire logic [1:0]  fi_pop_req,
    input wire logic [1:0]  fi_push_req,
    input wire logic [15:0] fi_etype0,
    input wire logic [15:0] fi_etype1,
    input wire logic [15:0] fi_etype2,
    input wire logic        fi_cls_hit,
    input wire logic [1:0]  fi_cls_pop,
    input wire logic [1:0]  fi_cls_outer,
    input wire logic        fi_cls_inner,
    input wire logic [1:0]  fi_cls_cust,
    input wire logic        fo_valid,
    input wire logic        fo_ready,
    input wire logic [1:0]  fo_pop_cnt,
    input wire logic [1:0]  fo_push_cnt,
    input wire logic [2:0]  fo_src0,
    input wire logic [2:0]  fo_src1,
    input wire logic [2:0]  fo_src2
);
    // ======================================================================
    // classifier enable tracked from bus writes, since it is not a port
    logic wr_q;
    logic en_q;
    logic acc;
    logic q3;
    assign acc = fi_valid && fi_ready;
    assign q3  = {fi_etype0, fi_etype1, fi_etype2} == {3{16'h8100}};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            en_q <= 1'b0;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
            if (wr_q)
                en_q <= hwdata[0];
        end
    end

    // ======================================================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    take_out_a: assert property (acc |=> fo_valid && !fi_ready)
        else $error("no result after an accepted frame");
    hold_out_a: assert property (fo_valid && !fo_ready |=> fo_valid &&
        $stable({fo_pop_cnt, fo_push_cnt, fo_src0, fo_src1, fo_src2}))
        else $error("result changed while stalled");
    pop_sat_a: assert property (acc && q3 && fi_pop_req == 2'h3 |=> fo_pop_cnt == 2'h3)
        else $error("pop count not saturated at three");
    pop_none_a: assert property (acc && fi_etype0 == 16'h0800 |=> fo_pop_cnt == 2'h0)
        else $error("pop without any leading q-tag");
    pop_cap_a: assert property (acc && fi_etype0 == 16'h8100 && fi_etype1 == 16'h0800
        |=> fo_pop_cnt <= 2'h1)
        else $error("pop count above counted q-tags");
    push_order_a: assert property (fo_valid && fo_push_cnt != 2'h0 |-> fo_src0 != 3'h0
        && (fo_push_cnt < 2'h2 || fo_src1 != 3'h0))
        else $error("pushed tag slot without source");
    cls_abc_a: assert property (acc && en_q && fi_cls_hit && fi_cls_outer == 2'h1
        && fi_cls_inner && fi_cls_cust == 2'h3
        |=> fo_push_cnt == 2'h3 && {fo_src0, fo_src1, fo_src2} == 9'h09c)
        else $error("classifier a b c push wrong");
    delta_push_a: assert property (acc && en_q && fi_cls_hit && fi_cls_outer == 2'h3
        && !fi_cls_inner && fi_cls_cust == 2'h0 && fi_cls_pop == 2'h0
        |=> fo_push_cnt == $past(fi_push_req))
        else $error("delta push wrong");
    delta_pop_a: assert property (acc && en_q && fi_cls_hit && q3 && fi_pop_req == 2'h0
        |=> fo_pop_cnt == ($past(fi_cls_pop) > $past(fi_push_req)
        ? $past(fi_cls_pop) - $past(fi_push_req) : 2'h0))
        else $error("delta pop wrong");
    cover property (acc && en_q && fi_cls_hit);
    cover property (fo_valid && !fo_ready);
    cover property (acc && q3 && fi_pop_req == 2'h3);
endmodule : evte_checker

bind evte_editor evte_checker i_evte_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .fi_valid(fi_valid), .fi_ready(fi_ready), .fi_pop_req(fi_pop_req),
    .fi_push_req(fi_push_req), .fi_etype0(fi_etype0), .fi_etype1(fi_etype1),
    .fi_etype2(fi_etype2), .fi_cls_hit(fi_cls_hit), .fi_cls_pop(fi_cls_pop),
    .fi_cls_outer(fi_cls_outer), .fi_cls_inner(fi_cls_inner), .fi_cls_cust(fi_cls_cust),
    .fo_valid(fo_valid), .fo_ready(fo_ready), .fo_pop_cnt(fo_pop_cnt),
    .fo_push_cnt(fo_push_cnt), .fo_src0(fo_src0), .fo_src1(fo_src1), .fo_src2(fo_src2));

/* testbench/evte_ana_model.sv */
// upstream analyzer model: descriptor handshake and push request
`timescale 1ns/100ps
module evte_ana_model
(
    input  wire logic       hclk,
    input  wire logic       fi_ready,
    output logic            fi_valid,
    output logic [1:0]      fi_push_req
);
    initial
    begin
        fi_valid    = 1'b0;
        fi_push_req = 2'h0;
    end

    // ======================================================================
    // request held until the editor takes it, then withdrawn
    task automatic send(input logic [1:0] push);
        fi_valid    <= 1'b1;
        fi_push_req <= push;
        do
            @(posedge hclk);
        while (fi_ready !== 1'b1);
        fi_valid    <= 1'b0;
        fi_push_req <= 2'h0;
    endtask : send
endmodule : evte_ana_model

/* testbench/evte_editor_tb.sv */
// self-checking bench for the egress vlan tag editor
`timescale 1ns/100ps
module evte_editor_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, port, pop, dp, cpop, outer, cust, fi_push_req;
    logic        orig, routed, hit, inner, fo_ready, fi_valid, fi_ready, fo_valid, fo_color;
    logic [11:0] vid;
    logic [15:0] e0, e1, e2;
    logic [1:0]  fo_pop_cnt, fo_push_cnt;
    logic [2:0]  fo_src0, fo_src1, fo_src2;
    logic [31:0] fo_port_tag;
    logic [32:0] ptag;
    logic [8:0]  srcs [4] = '{9'h000, 9'h080, 9'h098, 9'h09c};
    int          failures = 0, checks_done = 0;

    always #2.5 hclk = ~hclk;

    evte_editor i_evte_editor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .fi_valid(fi_valid),
        .fi_ready(fi_ready), .fi_port(port), .fi_pop_req(pop), .fi_push_req(fi_push_req),
        .fi_orig_tagged(orig), .fi_qos(3'h0), .fi_dp(dp), .fi_vid(vid), .fi_pcp(3'h5),
        .fi_dei(1'b0), .fi_routed(routed), .fi_route_vid(12'h0), .fi_etype0(e0),
        .fi_etype1(e1), .fi_etype2(e2), .fi_cls_hit(hit), .fi_cls_pop(cpop),
        .fi_cls_outer(outer), .fi_cls_inner(inner), .fi_cls_cust(cust),
        .fo_valid(fo_valid), .fo_ready(fo_ready), .fo_pop_cnt(fo_pop_cnt),
        .fo_push_cnt(fo_push_cnt), .fo_src0(fo_src0), .fo_src1(fo_src1), .fo_src2(fo_src2),
        .fo_port_tag(fo_port_tag), .fo_color(fo_color));
    evte_ana_model i_evte_ana_model (.hclk(hclk), .fi_ready(fi_ready), .fi_valid(fi_valid),
        .fi_push_req(fi_push_req));

    // ======================================================================
    // helpers
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // one single ahb-lite transfer; waits on hready, never assumes a latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do
            @(posedge hclk);
        while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do
            @(posedge hclk);
        while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check({hresp, q}, {1'b0, exp});
    endtask : rd

    task automatic cls(input logic h, i, input logic [1:0] o, c, p);
        hit   <= h;
        inner <= i;
        outer <= o;
        cust  <= c;
        cpop  <= p;
    endtask : cls

    // one frame through; the far side stalls three cycles before taking it
    task automatic frm(input logic [1:0] push, xpop, xpush, input logic [8:0] xsrc);
        int n;
        i_evte_ana_model.send(push);
        n = 0;
        while (fo_valid !== 1'b1 && n < 20)
        begin
            @(posedge hclk);
            n++;
        end
        repeat (2) @(posedge hclk);
        check({fo_pop_cnt, fo_push_cnt, fo_src0, fo_src1, fo_src2}, {xpop, xpush, xsrc});
        ptag = {fo_color, fo_port_tag};
        fo_ready <= 1'b1;
        @(posedge hclk);
        fo_ready <= 1'b0;
    endtask : frm

    // ======================================================================
    // tests
    initial
    begin
        {port, pop, dp, orig, routed, fo_ready, vid} = '0;
        {e0, e1, e2} = {16'h8100, 16'h0800, 16'h0800};
        cls(1'b1, 1'b1, 2'h1, 2'h3, 2'h0);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'hc);
        rd(8'h10, 32'h8100);
        rd(8'h44, 32'h3);
        rd(8'hfc, 32'h0);
        pop <= 2'h1;
        frm(2'h2, 2'h1, 2'h0, 9'h000);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h1);
        {pop, e0} <= {2'h0, 16'h0800};
        for (int i = 0; i < 4; i++)
        begin
            cls(1'b1, i > 1, i == 0 ? 2'h3 : 2'h1, i == 3 ? 2'h3 : 2'h0, 2'h0);
            frm(2'h0, 2'h0, i[1:0], srcs[i]);
        end
        cls(1'b1, 1'b0, 2'h1, 2'h0, 2'h0);
        frm(2'h2, 2'h0, 2'h3, 9'h09c);
        cls(1'b1, 1'b0, 2'h3, 2'h0, 2'h1);
        frm(2'h3, 2'h0, 2'h2, 9'h098);
        {pop, e0, e1, e2} <= {2'h3, {3{16'h8100}}};
        cls(1'b1, 1'b0, 2'h3, 2'h0, 2'h3);
        frm(2'h1, 2'h3, 2'h0, 9'h000);
        pop <= 2'h0;
        frm(2'h1, 2'h2, 2'h0, 9'h000);
        {pop, e1, e2} <= {2'h3, 16'h88a8, 16'h0800};
        cls(1'b0, 1'b0, 2'h0, 2'h0, 2'h0);
        frm(2'h0, 2'h2, 2'h0, 9'h000);
        wr(8'h08, 32'h9100);
        {e0, e1} <= {16'h9100, 16'h8100};
        frm(2'h0, 2'h2, 2'h0, 9'h000);
        {pop, dp} <= {2'h0, 2'h3};
        wr(8'h44, 32'h3110);
        frm(2'h0, 2'h0, 2'h1, 9'h040);
        check(ptag, {1'b1, 16'h88a8, 3'h5, 1'b1, 12'h001});
        wr(8'h44, 32'h3114);
        frm(2'h0, 2'h0, 2'h0, 9'h000);
        orig <= 1'b1;
        frm(2'h0, 2'h0, 2'h1, 9'h040);
        wr(8'h44, 32'h2);
        frm(2'h0, 2'h0, 2'h0, 9'h000);
        vid <= 12'h005;
        frm(2'h0, 2'h0, 2'h1, 9'h040);
        wr(8'h44, 32'h1);
        vid <= 12'h001;
        frm(2'h0, 2'h0, 2'h0, 9'h000);
        vid <= 12'h005;
        cls(1'b1, 1'b0, 2'h0, 2'h0, 2'h0);
        frm(2'h2, 2'h0, 2'h1, 9'h040);
        {routed, dp} <= {1'b0, 2'h0};
        wr(8'h44, 32'h400);
        wr(8'h48, 32'h6);
        frm(2'h0, 2'h0, 2'h1, 9'h040);
        check(ptag, {1'b0, 16'h8100, 3'h6, 1'b0, 12'h005});
        routed <= 1'b1;
        frm(2'h0, 2'h0, 2'h1, 9'h140);
        rd(8'h14, 32'h14);
        results();
    end

    // cut a hang short well after the tests' expected span
    initial
    begin
        #20000;
        failures++;
        results();
    end
endmodule : evte_editor_tb
